/* File: stsk_sink.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Stream sink controller: lands beats from a source, software drains them
// ----------------------------------------------------------------------

module stsk_sink (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Software register port
	input wire logic [stsk_pkg::ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Stream link from the source
	input wire logic i_valid,
	input wire stsk_pkg::stsk_beat_t i_beat,
	output logic o_ready
);
	// ------------------------------------------------------------------
	// Control register and legalised timing
	// ------------------------------------------------------------------
	logic [31:0] ctrl;
	logic ctl_en;
	logic ctl_crd_set;
	logic ctl_ewp;
	logic ctl_msb;
	logic [3:0] dly_raw;
	logic [3:0] crd_raw;
	logic [3:0] dly_eff;
	logic [3:0] crd_eff;

	// Software control word
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl <= stsk_pkg::CTRL_RESET;
		end else if (i_wr && i_addr == stsk_pkg::A_CTRL) begin
			ctrl <= i_wdata;
		end
	end

	assign ctl_en = ctrl[stsk_pkg::CTRL_EN];
	assign ctl_crd_set = ctrl[stsk_pkg::CTRL_CRD_SET];
	assign ctl_ewp = ctrl[stsk_pkg::CTRL_EWP];
	assign ctl_msb = ctrl[stsk_pkg::CTRL_MSB];
	assign dly_raw = ctrl[stsk_pkg::CTRL_DLY_LSB +: stsk_pkg::DELAY_W];
	assign crd_raw = ctrl[stsk_pkg::CTRL_CRD_LSB +: stsk_pkg::DELAY_W];

	// Clamp to 0..8; a wrong write cannot push the window past the store
	assign dly_eff = (dly_raw > stsk_pkg::DELAY_MAX) ? stsk_pkg::DELAY_MAX : dly_raw;

	// Credit: unset means the delay, never below a nonzero delay
	always_comb begin
		if (!ctl_crd_set) begin
			crd_eff = dly_eff;
		end else if (crd_raw > stsk_pkg::DELAY_MAX) begin
			crd_eff = stsk_pkg::DELAY_MAX;
		end else if (dly_eff != stsk_pkg::DELAY_ZERO && crd_raw < dly_eff) begin
			crd_eff = dly_eff;
		end else begin
			crd_eff = crd_raw;
		end
	end

	// ------------------------------------------------------------------
	// Accept window
	// ------------------------------------------------------------------
	logic ready_cycle;
	logic take;
	logic [3:0] credit_left;

	stsk_window u_window (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_ready(o_ready),
		.i_valid(i_valid),
		.i_delay(dly_eff),
		.i_credit(crd_eff),
		.o_ready_cycle(ready_cycle),
		.o_take(take),
		.o_credit_left(credit_left)
	);

	// ------------------------------------------------------------------
	// Landing store
	// ------------------------------------------------------------------
	stsk_pkg::stsk_beat_t mem [stsk_pkg::FIFO_DEPTH];
	stsk_pkg::stsk_beat_t landed;
	stsk_pkg::stsk_beat_t head;
	logic [stsk_pkg::PTR_W-1:0] wptr;
	logic [stsk_pkg::PTR_W-1:0] rptr;
	logic [stsk_pkg::CNT_W-1:0] count;
	logic full;
	logic push;
	logic pop;
	logic overrun;

	assign full = (count == stsk_pkg::FIFO_FULL);
	// Source fault tolerance is not our job; an overrun only sets a flag
	assign push = take && !full;
	assign overrun = take && full;
	assign pop = i_rd && i_addr == stsk_pkg::A_DATA && count != '0;
	assign head = mem[rptr];

	// Normalise the beat as it lands so software sees one layout
	always_comb begin
		landed = i_beat;
		if (!ctl_msb) begin
			landed.data = stsk_pkg::stsk_swap_units(i_beat.data);
		end
		// Empty means something only on the last beat unless counted throughout
		if (!ctl_ewp && !i_beat.last) begin
			landed.empty = '0;
		end
	end

	// Store write, taken only on qualified cycles
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wptr] <= landed;
		end
	end

	// Write pointer
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wptr <= '0;
		end else if (push) begin
			wptr <= wptr + 1'b1;
		end
	end

	// Read pointer, advanced by a data read
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rptr <= '0;
		end else if (pop) begin
			rptr <= rptr + 1'b1;
		end
	end

	// Fill level
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + 1'b1;
		end else if (pop && !push) begin
			count <= count - 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Ready generation
	// ------------------------------------------------------------------
	// Headroom covers one flop cycle plus delay plus credit at their maximum
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ready <= 1'b0;
		end else begin
			o_ready <= ctl_en && (count < stsk_pkg::READY_LIMIT);
		end
	end

	// ------------------------------------------------------------------
	// Statistics and sticky overrun
	// ------------------------------------------------------------------
	logic [31:0] beats;
	logic [31:0] errs;
	logic ovf;

	// Beats landed; a write to the counter clears it unless a beat lands in that cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			beats <= '0;
		end else if (push) begin
			beats <= beats + 1'b1;
		end else if (i_wr && i_addr == stsk_pkg::A_BEATS) begin
			beats <= '0;
		end
	end

	// Beats with any error bit; the meaning of each bit is software's
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			errs <= '0;
		end else if (push && i_beat.error != '0) begin
			errs <= errs + 1'b1;
		end else if (i_wr && i_addr == stsk_pkg::A_ERRS) begin
			errs <= '0;
		end
	end

	// Overrun flag; a new overrun beats a clear in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ovf <= 1'b0;
		end else if (overrun) begin
			ovf <= 1'b1;
		end else if (i_wr && i_addr == stsk_pkg::A_STATUS && i_wdata[stsk_pkg::ST_OVF]) begin
			ovf <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	logic [31:0] next_rdata;

	// Read mux; unmapped addresses and idle cycles read zero
	always_comb begin
		next_rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				stsk_pkg::A_CTRL: begin
					next_rdata = ctrl;
				end
				stsk_pkg::A_STATUS: begin
					next_rdata[stsk_pkg::ST_CNT_LSB +: stsk_pkg::CNT_W] = count;
					next_rdata[stsk_pkg::ST_OVF] = ovf;
					next_rdata[stsk_pkg::ST_RDY] = o_ready;
				end
				stsk_pkg::A_DATA: begin
					next_rdata = (count != '0) ? head.data : '0;
				end
				stsk_pkg::A_META: begin
					if (count != '0) begin
						next_rdata[stsk_pkg::MT_CHAN_LSB +: stsk_pkg::CHAN_W] = head.channel;
						next_rdata[stsk_pkg::MT_ERR_LSB +: stsk_pkg::ERR_W] = head.error;
						next_rdata[stsk_pkg::MT_EMPTY_LSB +: stsk_pkg::EMPTY_W] = head.empty;
						next_rdata[stsk_pkg::MT_FIRST] = head.first;
						next_rdata[stsk_pkg::MT_LAST] = head.last;
						next_rdata[stsk_pkg::MT_AVAIL] = 1'b1;
					end
				end
				stsk_pkg::A_BEATS: begin
					next_rdata = beats;
				end
				stsk_pkg::A_ERRS: begin
					next_rdata = errs;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	// Read data stand in the cycle after the strobe only
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence landed_beat_s;
		push && !pop;
	endsequence

	sequence count_up_s;
		count == $past(count) + 6'h01;
	endsequence

	store_capture_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		landed_beat_s |=> count_up_s)
		else $error("qualified beat not stored");

	idle_ignored_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(!i_valid && !pop) |=> count == $past(count))
		else $error("store changed without a valid beat");

	credit_floor_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		dly_eff != 4'h0 |-> crd_eff >= dly_eff)
		else $error("credit below nonzero delay");

	credit_default_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		!ctl_crd_set |-> crd_eff == dly_eff)
		else $error("unset credit differs from delay");

	ready_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(!ctl_en || count >= 6'h0e) |=> !o_ready)
		else $error("ready high without enable or headroom");

	error_count_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(push && i_beat.error != 2'b00) |=> errs == $past(errs) + 32'h0000_0001)
		else $error("errored beat not counted");

	empty_midpacket_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(push && !ctl_ewp && !i_beat.last) |=> mem[$past(wptr)].empty == 2'b00)
		else $error("empty kept on a middle beat");

	overrun_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		overrun |=> ovf)
		else $error("overrun flag lost");
endmodule : stsk_sink

/* File: stsk_window.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Shared constants, layouts and helpers of the stream sink controller
// ----------------------------------------------------------------------
package stsk_pkg;
	// Link shape, fixed at build time
	localparam int DATA_W = 32;
	localparam int BITS_PER_UNIT = 8;
	localparam int UNITS_PER_TRANSFER = 4;
	localparam int BEATS_EACH_CLOCK = 1;
	localparam int CHAN_W = 8;
	localparam int ERR_W = 2;
	localparam int EMPTY_W = 2;
	localparam logic [7:0] HIGHEST_CHANNEL_NUMBER = 8'hff;
	// Handshake timing fields
	localparam int DELAY_W = 4;
	localparam logic [3:0] DELAY_MAX = 4'h8;
	localparam logic [3:0] DELAY_ZERO = 4'h0;
	localparam logic [3:0] DELAY_ONE = 4'h1;
	localparam int HIST_W = 8;
	// Landing store
	localparam int FIFO_DEPTH = 32;
	localparam int PTR_W = 5;
	localparam int CNT_W = 6;
	localparam logic [5:0] FIFO_FULL = 6'h20;
	localparam logic [5:0] READY_LIMIT = 6'h0e;
	// Register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_DATA = 8'h08;
	localparam logic [7:0] A_META = 8'h0c;
	localparam logic [7:0] A_BEATS = 8'h10;
	localparam logic [7:0] A_ERRS = 8'h14;
	// Control fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_DLY_LSB = 4;
	localparam int CTRL_CRD_LSB = 8;
	localparam int CTRL_CRD_SET = 12;
	localparam int CTRL_EWP = 13;
	localparam int CTRL_MSB = 14;
	localparam logic [31:0] CTRL_RESET = 32'h0000_4000;
	// Status fields
	localparam int ST_CNT_LSB = 0;
	localparam int ST_OVF = 8;
	localparam int ST_RDY = 9;
	// Beat description fields
	localparam int MT_CHAN_LSB = 0;
	localparam int MT_ERR_LSB = 8;
	localparam int MT_EMPTY_LSB = 10;
	localparam int MT_FIRST = 12;
	localparam int MT_LAST = 13;
	localparam int MT_AVAIL = 31;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [CHAN_W-1:0] channel;
		logic [ERR_W-1:0] error;
		logic [EMPTY_W-1:0] empty;
		logic first;
		logic last;
	} stsk_beat_t;

	// Swap unit order so the first unit always lands in the top bits
	function automatic logic [DATA_W-1:0] stsk_swap_units(input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		r = '0;
		for (int u = 0; u < UNITS_PER_TRANSFER; u++) begin
			r[u*BITS_PER_UNIT +: BITS_PER_UNIT] =
				d[(UNITS_PER_TRANSFER-1-u)*BITS_PER_UNIT +: BITS_PER_UNIT];
		end
		return r;
	endfunction : stsk_swap_units
endpackage : stsk_pkg

// ----------------------------------------------------------------------
// Ready-cycle tracker: turns our ready history into the accept window
// ----------------------------------------------------------------------
module stsk_window (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Handshake state
	input wire logic i_ready,
	input wire logic i_valid,
	// Timing settings, already legalised
	input wire logic [3:0] i_delay,
	input wire logic [3:0] i_credit,
	// Window outputs
	output logic o_ready_cycle,
	output logic o_take,
	output logic [3:0] o_credit_left
);
	logic [stsk_pkg::HIST_W-1:0] ready_hist;

	// Ready seen in earlier cycles, newest in bit 0
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ready_hist <= '0;
		end else begin
			ready_hist <= {ready_hist[stsk_pkg::HIST_W-2:0], i_ready};
		end
	end

	// Ready at n makes n plus delay a ready cycle
	assign o_ready_cycle = (i_delay == stsk_pkg::DELAY_ZERO) ? i_ready :
		ready_hist[3'(i_delay - stsk_pkg::DELAY_ONE)];

	// Credit reloads in every ready cycle, spent one per late transfer
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_credit_left <= '0;
		end else if (o_ready_cycle) begin
			o_credit_left <= i_credit;
		end else if (o_take && o_credit_left != stsk_pkg::DELAY_ZERO) begin
			o_credit_left <= o_credit_left - stsk_pkg::DELAY_ONE;
		end
	end

	// Qualified beat: valid in a ready cycle or inside the credit
	assign o_take = i_valid && (o_ready_cycle || o_credit_left != stsk_pkg::DELAY_ZERO);

	sequence ready_two_ago_s;
		i_ready ##2 1'b1;
	endsequence

	ready_delay_two_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_delay == 4'h2) ##0 ready_two_ago_s |-> (o_ready_cycle || $past(i_delay) != 4'h2))
		else $error("ready cycle missing two cycles after ready");

	late_take_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(o_take && !o_ready_cycle) |=> (o_ready_cycle || o_credit_left == $past(o_credit_left) - 4'h1))
		else $error("late transfer did not spend credit");

	zero_credit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_delay == 4'h0 && o_credit_left == 4'h0 && !i_ready) |-> !o_take)
		else $error("transfer taken with ready low and no credit");
endmodule : stsk_window

/* File: stsk_src_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Source model: queues beats, offers them inside the ready window, or at any time in rogue mode
// ----------------------------------------------------------------------
module stsk_src_model (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Settings and modes
	input wire logic [3:0] i_delay,
	input wire logic [3:0] i_credit,
	input wire logic i_use_credit,
	input wire logic i_stall,
	input wire logic i_rogue,
	// Queue loading
	input wire logic i_push,
	input wire stsk_pkg::stsk_beat_t i_push_beat,
	// Link
	input wire logic i_ready,
	output logic o_valid,
	output stsk_pkg::stsk_beat_t o_beat,
	output logic [7:0] o_sent
);
	stsk_pkg::stsk_beat_t beat_q[$];
	logic [7:0] hist;
	logic [8:0] sh;
	logic [3:0] credit_left;
	logic [3:0] next_credit;
	logic rc_now;
	logic rc_next;
	logic gone;
	logic send;

	// Ready history, newest in bit 0
	assign sh = {hist, i_ready};
	assign rc_now = sh[i_delay];
	assign rc_next = (i_delay != 4'h0) && sh[i_delay - 4'h1];
	assign gone = o_valid && (rc_now || i_rogue || (i_use_credit && credit_left != 4'h0));
	// Credit reloads in ready cycles, spent outside them
	assign next_credit = rc_now ? i_credit :
		((gone && credit_left != 4'h0) ? credit_left - 4'h1 : credit_left);

	// All link outputs from rising-edge flops
	always @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hist <= '0;
			credit_left <= '0;
			o_valid <= 1'b0;
			o_sent <= '0;
			beat_q.delete();
		end else begin
			hist <= sh[7:0];
			credit_left <= next_credit;
			if (gone) begin
				void'(beat_q.pop_front());
				o_sent <= o_sent + 8'h01;
			end
			if (i_push) begin
				beat_q.push_back(i_push_beat);
			end
			// Zero delay: an offered beat waits for the sink
			send = (o_valid && !gone) || (beat_q.size() != 0 && !i_stall && (i_rogue ||
				i_delay == 4'h0 || rc_next || (i_use_credit && next_credit != 4'h0)));
			o_valid <= send;
			// One beat, one channel; idle lines carry junk
			o_beat <= send ? beat_q[0] : ~o_beat;
		end
	end
endmodule : stsk_src_model

/* File: tb_stsk_sink.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Bench for the stream sink controller
// ----------------------------------------------------------------------
module tb_stsk_sink;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [3:0] delay;
		stsk_pkg::stsk_beat_t beat;
		logic [31:0] exp_data;
		logic [31:0] exp_meta;
	} stsk_tb_row_t;

	logic i_sys_clk = 1'b0;
	logic i_rst_b;
	logic [7:0] i_addr;
	logic [31:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [31:0] o_rdata;
	logic i_valid;
	stsk_pkg::stsk_beat_t i_beat;
	logic o_ready;
	logic [3:0] m_delay;
	logic [3:0] m_credit;
	logic m_use_credit;
	logic m_stall;
	logic m_rogue;
	logic m_push;
	stsk_pkg::stsk_beat_t m_push_beat;
	logic [7:0] m_sent;
	int fails = 0;
	int comparisons = 0;
	int total = 0;
	int base;
	logic [31:0] rdv;
	logic [31:0] exp_q[$];
	stsk_tb_row_t rows[4];
	logic [31:0] cfgs[4];
	logic [3:0] cdel[4];
	logic [3:0] ccrd[4];

	// 50 MHz clock
	always #10 i_sys_clk = ~i_sys_clk;

	stsk_sink dut_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_valid(i_valid), .i_beat(i_beat), .o_ready(o_ready));
	stsk_src_model src_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_delay(m_delay),
		.i_credit(m_credit), .i_use_credit(m_use_credit), .i_stall(m_stall),
		.i_rogue(m_rogue), .i_push(m_push), .i_push_beat(m_push_beat), .i_ready(o_ready),
		.o_valid(i_valid), .o_beat(i_beat), .o_sent(m_sent));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic results();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 rdv = o_rdata;
	endtask : rd

	task automatic push(input stsk_pkg::stsk_beat_t b, input logic [31:0] e);
		@(posedge i_sys_clk);
		m_push <= 1'b1;
		m_push_beat <= b;
		exp_q.push_back(e);
		total++;
	endtask : push

	// Bounded waits; running out counts as a mismatch
	task automatic wait_sent();
		int n;
		for (n = 0; n < 400 && m_sent !== 8'(total); n++) @(posedge i_sys_clk);
		if (n == 400) begin
			fails++;
			results();
		end
	endtask : wait_sent

	task automatic drain(input int cnt);
		int n;
		repeat (cnt) begin
			for (n = 0; n < 60; n++) begin
				rd(stsk_pkg::A_STATUS);
				if (rdv[5:0] != 6'h00) break;
			end
			if (n == 60) begin
				fails++;
				results();
			end
			rd(stsk_pkg::A_DATA);
			chk(rdv, exp_q.pop_front());
		end
	endtask : drain

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		// Ordinary cases: settings, beat, expected data and description
		rows[0] = '{32'h0000_4001, 4'h0, '{32'h1122_3344, 8'h05, 2'h0, 2'h3, 1'b1, 1'b1},
			32'h1122_3344, 32'h8000_3c05};
		rows[1] = '{32'h0000_0011, 4'h1, '{32'h1122_3344, 8'hff, 2'h2, 2'h2, 1'b1, 1'b0},
			32'h4433_2211, 32'h8000_12ff};
		rows[2] = '{32'h0000_6021, 4'h2, '{32'hdead_beef, 8'h00, 2'h1, 2'h2, 1'b0, 1'b0},
			32'hdead_beef, 32'h8000_0900};
		rows[3] = '{32'h0000_4081, 4'h8, '{32'h0102_0304, 8'h80, 2'h3, 2'h1, 1'b0, 1'b1},
			32'h0102_0304, 32'h8000_2780};
		// Backpressure settings: delay 0, 1 with credit 2, 2 unset, 3 with credit 1 raised to 3
		cfgs = '{32'h0000_4001, 32'h0000_5211, 32'h0000_4021, 32'h0000_5131};
		cdel = '{4'h0, 4'h1, 4'h2, 4'h3};
		ccrd = '{4'h0, 4'h2, 4'h2, 4'h3};
		i_rst_b = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0000_0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		m_delay = 4'h0;
		m_credit = 4'h0;
		m_use_credit = 1'b0;
		m_stall = 1'b0;
		m_rogue = 1'b0;
		m_push = 1'b0;
		m_push_beat = '0;
		repeat (16) @(posedge i_sys_clk);
		chk({31'h0, o_ready}, 32'h0000_0000);
		chk({31'h0, i_valid}, 32'h0000_0000);
		i_rst_b <= 1'b1;
		rd(stsk_pkg::A_CTRL);
		chk(rdv, stsk_pkg::CTRL_RESET);
		rd(stsk_pkg::A_STATUS);
		chk(rdv, 32'h0000_0000);
		rd(8'h1c);
		chk(rdv, 32'h0000_0000);
		rd(stsk_pkg::A_DATA);
		chk(rdv, 32'h0000_0000);
		$display("reset test done");
		foreach (rows[r]) begin
			m_delay <= rows[r].delay;
			wr(stsk_pkg::A_CTRL, rows[r].ctrl);
			push(rows[r].beat, rows[r].exp_data);
			@(posedge i_sys_clk);
			m_push <= 1'b0;
			wait_sent();
			rd(stsk_pkg::A_META);
			chk(rdv, rows[r].exp_meta);
			drain(1);
		end
		rd(stsk_pkg::A_BEATS);
		chk(rdv, 32'h0000_0004);
		rd(stsk_pkg::A_ERRS);
		chk(rdv, 32'h0000_0003);
		wr(stsk_pkg::A_BEATS, 32'h0000_0000);
		rd(stsk_pkg::A_BEATS);
		chk(rdv, 32'h0000_0000);
		$display("row tests done");
		// Fill until ready drops, let credit run out, then drain
		foreach (cfgs[c]) begin
			base = total;
			m_delay <= cdel[c];
			m_credit <= ccrd[c];
			m_use_credit <= (c != 0);
			m_stall <= 1'b1;
			wr(stsk_pkg::A_CTRL, cfgs[c]);
			for (int i = 0; i < 20; i++) begin
				push('{32'h5000_0000 + 32'(i), 8'h01, 2'h0, 2'h0, i == 0, i == 19},
					32'h5000_0000 + 32'(i));
			end
			@(posedge i_sys_clk);
			m_push <= 1'b0;
			repeat (10) @(posedge i_sys_clk);
			m_stall <= 1'b0;
			repeat (40) @(posedge i_sys_clk);
			chk({31'h0, o_ready}, 32'h0000_0000);
			rd(stsk_pkg::A_STATUS);
			chk(rdv, 32'(m_sent) - 32'(base));
			drain(20);
			wait_sent();
			$display("backpressure test %0d done", c);
		end
		// Beats offered outside any ready cycle are ignored
		m_rogue <= 1'b1;
		wr(stsk_pkg::A_CTRL, 32'h0000_4000);
		repeat (3) push('{32'h0bad_0bad, 8'h02, 2'h1, 2'h0, 1'b1, 1'b1}, 32'h0000_0000);
		@(posedge i_sys_clk);
		m_push <= 1'b0;
		wait_sent();
		rd(stsk_pkg::A_STATUS);
		chk(rdv, 32'h0000_0000);
		rd(stsk_pkg::A_META);
		chk(rdv, 32'h0000_0000);
		$display("refusal test done");
		// Reset in mid-run with ready up and a beat about to be offered
		wr(stsk_pkg::A_CTRL, 32'h0000_4001);
		push('{32'h0000_00aa, 8'h03, 2'h0, 2'h0, 1'b1, 1'b1}, 32'h0000_00aa);
		@(posedge i_sys_clk);
		m_push <= 1'b0;
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		chk({31'h0, o_ready}, 32'h0000_0000);
		chk({31'h0, i_valid}, 32'h0000_0000);
		chk(o_rdata, 32'h0000_0000);
		i_rst_b <= 1'b1;
		rd(stsk_pkg::A_STATUS);
		chk(rdv, 32'h0000_0000);
		rd(stsk_pkg::A_CTRL);
		chk(rdv, stsk_pkg::CTRL_RESET);
		rd(stsk_pkg::A_BEATS);
		chk(rdv, 32'h0000_0000);
		$display("mid-run reset test done");
		results();
	end
endmodule : tb_stsk_sink
